// File: common/ret_pkg.sv
// ret_pkg: constants, register map and field layout of the event timer set
// assumes a 100 MHz register clock and a 13.56 MHz interface tick made here
//
// Overview of operation
// - timer A status: busy at bit 20, count in 19:0, zero at reset.
// - timer B status: live count in bits 19:0, busy flag in bit 20.
// - timer C status: busy in bit 20, count in 19:0, zero at reset.
// - timer A preset in reload bits 19:0, writable, resets zero, upper reserved.
// - timer B preset in reload bits 19:0, writable, resets zero, upper reserved.
// - timer C preset in reload bits 19:0, writable, resets zero, upper reserved.
// - setup bit 20 halts timer A once reception began and 4 bits arrived.
// - setup bit 19 halts timer A when a transmission begins.
// - setup bit 18 halts timer A when an external field appears.
// - setup bit 17 halts timer A when the external field vanishes.
// - setup bit 16 halts timer A when the own field turns on.
// - setup bit 15 halts timer A when the own field turns off.
// - setup bit 14 starts timer A on the first received bit.
// - setup bit 13 starts timer A when a reception ends.
// - setup bit 12 starts timer A when a transmission starts.
// - setup bit 11 starts timer A when a transmission completes.
// - setup bit 10 starts timer A when an external field appears.
// - setup bit 9 starts timer A when the external field is lost.
// - setup bit 8 starts timer A when the own field turns on.
// - setup bit 7 starts timer A when the own field turns off.
// - setup bit 6 starts timer A immediately.
// - autoreload bit 1 clear stops at zero; set reloads preset, keeps counting.
// - timer A runs only while enable bit 0 is set; resets zero.
// - clock select bit 2: clear counts 13.56 MHz ticks, set prescaled ticks.
// - prescale code bits 3 to 5 halves rate per step, 6.78 MHz to 53 kHz.

package ret_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CNT_W  = 20;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SETUP_W = 21;
  localparam int NUM_TIMERS = 3;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_A_STATUS  = 6'h08;
  localparam logic [5:0] IDX_B_STATUS  = 6'h09;
  localparam logic [5:0] IDX_C_STATUS  = 6'h0a;
  localparam logic [5:0] IDX_A_PRELOAD = 6'h0b;
  localparam logic [5:0] IDX_B_PRELOAD = 6'h0c;
  localparam logic [5:0] IDX_C_PRELOAD = 6'h0d;
  localparam logic [5:0] IDX_A_SETUP   = 6'h0e;
  localparam logic [5:0] IDX_BC_CTRL   = 6'h10;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int ST_BUSY_BIT = 20;

  // ---------------------------------------------------------------
  // timer A setup field positions
  // ---------------------------------------------------------------
  localparam int SU_HALT_RX_BEGIN    = 20;
  localparam int SU_HALT_TX_BEGIN    = 19;
  localparam int SU_HALT_EXT_UP      = 18;
  localparam int SU_HALT_EXT_GONE    = 17;
  localparam int SU_HALT_OWN_UP      = 16;
  localparam int SU_HALT_OWN_DOWN    = 15;
  localparam int SU_GO_RX_BEGIN      = 14;
  localparam int SU_GO_RX_END        = 13;
  localparam int SU_GO_TX_BEGIN      = 12;
  localparam int SU_GO_TX_END        = 11;
  localparam int SU_GO_EXT_UP        = 10;
  localparam int SU_GO_EXT_GONE      = 9;
  localparam int SU_GO_OWN_UP        = 8;
  localparam int SU_GO_OWN_DOWN      = 7;
  localparam int SU_GO_IMMEDIATE     = 6;
  localparam int SU_DIV_LSB          = 3;
  localparam int SU_DIV_MSB          = 5;
  localparam int SU_CLOCK_SOURCE     = 2;
  localparam int SU_AUTORELOAD       = 1;
  localparam int SU_ON               = 0;

  // ---------------------------------------------------------------
  // timer B/C control field positions (C sits at B plus 8)
  // ---------------------------------------------------------------
  localparam int BC_ON         = 0;
  localparam int BC_AUTORELOAD = 1;
  localparam int BC_GO         = 2;
  localparam int BC_HALT       = 3;
  localparam int BC_C_OFFSET   = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0]   PRESET_RST = 20'h00000;
  localparam logic [SETUP_W-1:0] SETUP_RST  = 21'h000000;
  localparam logic [15:0]        BC_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // timing: interface tick derived from the register clock
  // ---------------------------------------------------------------
  localparam int REF_CLK_KHZ = 100000;
  localparam int IF_CLK_KHZ  = 13560;
  localparam int PHASE_W     = 17;
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(IF_CLK_KHZ);
  localparam logic [PHASE_W-1:0] PHASE_MOD  = PHASE_W'(REF_CLK_KHZ);
  localparam int PRESCALE_W  = 8;

endpackage

// File: rtl/ret_timer_core.sv
// ret_timer_core: one 20-bit down counter with busy flag and preset
// assumes tick, go and halt are one-cycle pulses in the ref clock domain

module ret_timer_core
  import ret_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // control
  input  wire logic             tick_i,
  input  wire logic             on_i,
  input  wire logic             autoreload_i,
  input  wire logic [CNT_W-1:0] preset_i,
  input  wire logic             go_i,
  input  wire logic             halt_i,
  // state
  output logic      [CNT_W-1:0] count_o,
  output logic                  busy_o
);

  logic [CNT_W-1:0] count_r;
  logic             busy_r;

  // ---------------------------------------------------------------
  // counter: halt beats go, go beats a tick
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
      busy_r  <= 1'b0;
    end else if (!on_i) begin
      busy_r <= 1'b0;
    end else if (halt_i) begin
      busy_r <= 1'b0;
    end else if (go_i) begin
      count_r <= preset_i;
      busy_r  <= 1'b1;
    end else if (busy_r && tick_i) begin
      if (count_r != '0) begin
        count_r <= count_r - CNT_W'(1);
      end else if (autoreload_i) begin
        count_r <= preset_i;
      end else begin
        busy_r <= 1'b0;
      end
    end
  end

  assign count_o = count_r;
  assign busy_o  = busy_r;

endmodule

// File: rtl/ret_top.sv
// ret_top: three event timers with register port and field/transceiver events
// assumes event inputs are synchronous one-cycle pulses, field inputs levels

module ret_top
  import ret_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // transceiver events
  input  wire logic              rx_begin_i,
  input  wire logic              rx_nibble_i,
  input  wire logic              rx_end_i,
  input  wire logic              tx_begin_i,
  input  wire logic              tx_end_i,
  // field levels
  input  wire logic              ext_field_i,
  input  wire logic              own_field_i,
  // timer state
  output logic                   timer_a_busy_o,
  output logic                   timer_b_busy_o,
  output logic                   timer_c_busy_o
);

  // ---------------------------------------------------------------
  // decode helper
  // ---------------------------------------------------------------

  // true when a byte address hits a word index
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [5:0]        idx);
    hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
  endfunction

  // mask of low prescaler bits that must all be one for a divided tick
  function automatic logic [PRESCALE_W-1:0] div_mask(input logic [2:0] code);
    div_mask = PRESCALE_W'((9'h002 << code) - 9'h001);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]   timer_a_preset_r;
  logic [CNT_W-1:0]   timer_b_preset_r;
  logic [CNT_W-1:0]   timer_c_preset_r;
  logic [SETUP_W-1:0] timer_a_setup_r;
  logic [15:0]        bc_ctrl_r;
  logic [DATA_W-1:0]  rdata_r;
  logic [DATA_W-1:0]  rdata_nxt;

  // tick generation
  logic [PHASE_W-1:0]    phase_r;
  logic [PHASE_W:0]      phase_sum;
  logic                  if_tick_r;
  logic [PRESCALE_W-1:0] presc_r;
  logic                  div_tick;
  logic                  timer_a_tick;

  // event edges
  logic ext_field_r;
  logic own_field_r;
  logic ext_up;
  logic ext_gone;
  logic own_up;
  logic own_down;

  // timer A triggers
  logic timer_a_halt_trigger;
  logic timer_a_go_trigger;
  logic imm_go;

  // per timer vectors
  logic [NUM_TIMERS-1:0] t_tick;
  logic [NUM_TIMERS-1:0] t_on;
  logic [NUM_TIMERS-1:0] t_arl;
  logic [NUM_TIMERS-1:0] t_go;
  logic [NUM_TIMERS-1:0] t_halt;
  logic [NUM_TIMERS-1:0] t_busy;
  logic [CNT_W-1:0]      t_preset [NUM_TIMERS];
  logic [CNT_W-1:0]      t_count  [NUM_TIMERS];

  // write strobes per register
  logic wr_a_pre;
  logic wr_b_pre;
  logic wr_c_pre;
  logic wr_a_setup;
  logic wr_bc;

  assign wr_a_pre   = reg_wr_i && hit(reg_addr_i, IDX_A_PRELOAD);
  assign wr_b_pre   = reg_wr_i && hit(reg_addr_i, IDX_B_PRELOAD);
  assign wr_c_pre   = reg_wr_i && hit(reg_addr_i, IDX_C_PRELOAD);
  assign wr_a_setup = reg_wr_i && hit(reg_addr_i, IDX_A_SETUP);
  assign wr_bc      = reg_wr_i && hit(reg_addr_i, IDX_BC_CTRL);

  // ---------------------------------------------------------------
  // preset registers; reserved upper bits are dropped
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_a_preset_r <= PRESET_RST;
    end else if (wr_a_pre) begin
      timer_a_preset_r <= reg_wdata_i[CNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_b_preset_r <= PRESET_RST;
    end else if (wr_b_pre) begin
      timer_b_preset_r <= reg_wdata_i[CNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_c_preset_r <= PRESET_RST;
    end else if (wr_c_pre) begin
      timer_c_preset_r <= reg_wdata_i[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // timer A setup and timer B/C control
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_a_setup_r <= SETUP_RST;
    end else if (wr_a_setup) begin
      timer_a_setup_r <= reg_wdata_i[SETUP_W-1:0];
    end
  end

  // go and halt bits are self-clearing strobes, not stored
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bc_ctrl_r <= BC_RST;
    end else if (wr_bc) begin
      bc_ctrl_r <= reg_wdata_i[15:0] & 16'h0303;
    end
  end

  // immediate start fires once, on the write that sets the bit
  assign imm_go = wr_a_setup && reg_wdata_i[SU_GO_IMMEDIATE]
                  && reg_wdata_i[SU_ON];

  // ---------------------------------------------------------------
  // interface tick: 13.56 MHz average from a phase accumulator
  // ---------------------------------------------------------------
  assign phase_sum = {1'b0, phase_r} + {1'b0, PHASE_STEP};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r   <= '0;
      if_tick_r <= 1'b0;
    end else if (phase_sum >= {1'b0, PHASE_MOD}) begin
      phase_r   <= PHASE_W'(phase_sum - {1'b0, PHASE_MOD});
      if_tick_r <= 1'b1;
    end else begin
      phase_r   <= phase_sum[PHASE_W-1:0];
      if_tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // prescaler: code n divides the interface tick by 2^(n+1)
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_r <= '0;
    end else if (if_tick_r) begin
      presc_r <= presc_r + PRESCALE_W'(1);
    end
  end

  assign div_tick = if_tick_r &&
    ((presc_r & div_mask(timer_a_setup_r[SU_DIV_MSB:SU_DIV_LSB]))
     == div_mask(timer_a_setup_r[SU_DIV_MSB:SU_DIV_LSB]));

  assign timer_a_tick = timer_a_setup_r[SU_CLOCK_SOURCE] ?
                        div_tick : if_tick_r;

  // ---------------------------------------------------------------
  // field edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_field_r <= 1'b0;
      own_field_r <= 1'b0;
    end else begin
      ext_field_r <= ext_field_i;
      own_field_r <= own_field_i;
    end
  end

  assign ext_up   =  ext_field_i && !ext_field_r;
  assign ext_gone = !ext_field_i &&  ext_field_r;
  assign own_up   =  own_field_i && !own_field_r;
  assign own_down = !own_field_i &&  own_field_r;

  // ---------------------------------------------------------------
  // timer A halt and go triggers
  // ---------------------------------------------------------------
  always_comb begin
    timer_a_halt_trigger =
        (timer_a_setup_r[SU_HALT_RX_BEGIN] && rx_nibble_i)
      | (timer_a_setup_r[SU_HALT_TX_BEGIN] && tx_begin_i)
      | (timer_a_setup_r[SU_HALT_EXT_UP]   && ext_up)
      | (timer_a_setup_r[SU_HALT_EXT_GONE] && ext_gone)
      | (timer_a_setup_r[SU_HALT_OWN_UP]   && own_up)
      | (timer_a_setup_r[SU_HALT_OWN_DOWN] && own_down);
  end

  always_comb begin
    timer_a_go_trigger =
        (timer_a_setup_r[SU_GO_RX_BEGIN]   && rx_begin_i)
      | (timer_a_setup_r[SU_GO_RX_END]     && rx_end_i)
      | (timer_a_setup_r[SU_GO_TX_BEGIN]   && tx_begin_i)
      | (timer_a_setup_r[SU_GO_TX_END]     && tx_end_i)
      | (timer_a_setup_r[SU_GO_EXT_UP]     && ext_up)
      | (timer_a_setup_r[SU_GO_EXT_GONE]   && ext_gone)
      | (timer_a_setup_r[SU_GO_OWN_UP]     && own_up)
      | (timer_a_setup_r[SU_GO_OWN_DOWN]   && own_down)
      | imm_go;
  end

  // ---------------------------------------------------------------
  // per-timer hookup
  // ---------------------------------------------------------------
  assign t_tick[0]   = timer_a_tick;
  // a setup write acts in the cycle it lands, so enable plus
  // immediate start in one write is not refused by the old enable
  assign t_on[0]     = wr_a_setup ? reg_wdata_i[SU_ON]
                                  : timer_a_setup_r[SU_ON];
  assign t_arl[0]    = timer_a_setup_r[SU_AUTORELOAD];
  assign t_go[0]     = timer_a_go_trigger;
  assign t_halt[0]   = timer_a_halt_trigger;
  assign t_preset[0] = timer_a_preset_r;

  // timers B and C count interface ticks, started by software
  assign t_tick[1]   = if_tick_r;
  assign t_on[1]     = wr_bc ? reg_wdata_i[BC_ON] : bc_ctrl_r[BC_ON];
  assign t_arl[1]    = bc_ctrl_r[BC_AUTORELOAD];
  assign t_go[1]     = wr_bc && reg_wdata_i[BC_GO];
  assign t_halt[1]   = wr_bc && reg_wdata_i[BC_HALT];
  assign t_preset[1] = timer_b_preset_r;

  assign t_tick[2]   = if_tick_r;
  assign t_on[2]     = wr_bc ? reg_wdata_i[BC_C_OFFSET + BC_ON]
                             : bc_ctrl_r[BC_C_OFFSET + BC_ON];
  assign t_arl[2]    = bc_ctrl_r[BC_C_OFFSET + BC_AUTORELOAD];
  assign t_go[2]     = wr_bc && reg_wdata_i[BC_C_OFFSET + BC_GO];
  assign t_halt[2]   = wr_bc && reg_wdata_i[BC_C_OFFSET + BC_HALT];
  assign t_preset[2] = timer_c_preset_r;

  // ---------------------------------------------------------------
  // timer instances
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
    ret_timer_core u_core (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_i),
      .tick_i       (t_tick[g]),
      .on_i         (t_on[g]),
      .autoreload_i (t_arl[g]),
      .preset_i     (t_preset[g]),
      .go_i         (t_go[g]),
      .halt_i       (t_halt[g]),
      .count_o      (t_count[g]),
      .busy_o       (t_busy[g])
    );
  end

  assign timer_a_busy_o = t_busy[0];
  assign timer_b_busy_o = t_busy[1];
  assign timer_c_busy_o = t_busy[2];

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (hit(reg_addr_i, IDX_A_STATUS)) begin
      rdata_nxt[ST_BUSY_BIT] = t_busy[0];
      rdata_nxt[CNT_W-1:0]   = t_count[0];
    end else if (hit(reg_addr_i, IDX_B_STATUS)) begin
      rdata_nxt[ST_BUSY_BIT] = t_busy[1];
      rdata_nxt[CNT_W-1:0]   = t_count[1];
    end else if (hit(reg_addr_i, IDX_C_STATUS)) begin
      rdata_nxt[ST_BUSY_BIT] = t_busy[2];
      rdata_nxt[CNT_W-1:0]   = t_count[2];
    end else if (hit(reg_addr_i, IDX_A_PRELOAD)) begin
      rdata_nxt[CNT_W-1:0] = timer_a_preset_r;
    end else if (hit(reg_addr_i, IDX_B_PRELOAD)) begin
      rdata_nxt[CNT_W-1:0] = timer_b_preset_r;
    end else if (hit(reg_addr_i, IDX_C_PRELOAD)) begin
      rdata_nxt[CNT_W-1:0] = timer_c_preset_r;
    end else if (hit(reg_addr_i, IDX_A_SETUP)) begin
      rdata_nxt[SETUP_W-1:0] = timer_a_setup_r;
    end else if (hit(reg_addr_i, IDX_BC_CTRL)) begin
      rdata_nxt[15:0] = bc_ctrl_r;
    end
  end

  // read data held one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

// File: sim/ret_checker_assertions.sv
// ret_checker: port-level checks of the event timer set
// assumes it is bound to ret_top and sees its ports only
module ret_checker
  import ret_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // events and fields
  input wire logic              rx_begin_i,
  input wire logic              rx_end_i,
  input wire logic              tx_begin_i,
  input wire logic              tx_end_i,
  input wire logic              ext_field_i,
  input wire logic              own_field_i,
  // timer state
  input wire logic              timer_a_busy_o,
  input wire logic              timer_b_busy_o,
  input wire logic              timer_c_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SETUP_W-1:0] setup_r;

  // ---------------------------------------------------------------
  // shadow of timer A setup, then checks
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      setup_r <= SETUP_RST;
    else if (reg_wr_i && reg_addr_i == 8'h38)
      setup_r <= reg_wdata_i[SETUP_W-1:0];
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("rdata not idle");
  a_busy_a_status: assert property (
    s_rd(8'h20) |=> reg_rdata_o[20] == $past(timer_a_busy_o))
    else $error("status A busy bit");
  a_busy_b_status: assert property (
    s_rd(8'h24) |=> reg_rdata_o[20] == $past(timer_b_busy_o))
    else $error("status B busy bit");
  a_busy_c_status: assert property (
    s_rd(8'h28) |=> reg_rdata_o[20] == $past(timer_c_busy_o))
    else $error("status C busy bit");
  a_preset_upper_zero: assert property (
    reg_rd_i && reg_addr_i inside {8'h2c, 8'h30, 8'h34}
    |=> reg_rdata_o[31:20] == 12'h000) else $error("preset upper bits");
  a_off_stops_a: assert property (
    reg_wr_i && reg_addr_i == 8'h38 && !reg_wdata_i[0]
    |=> !timer_a_busy_o) else $error("A busy after disable");
  a_busy_a_enabled: assert property (
    $rose(timer_a_busy_o) |-> setup_r[0]) else $error("A runs while off");
  a_tx_halt_a: assert property (
    tx_begin_i && setup_r[19] && !reg_wr_i |=> !timer_a_busy_o)
    else $error("A not halted on tx");
  a_ext_halt_a: assert property (
    $rose(ext_field_i) && setup_r[18] && !reg_wr_i |=> !timer_a_busy_o)
    else $error("A not halted on field");
  a_busy_a_cause: assert property (
    $rose(timer_a_busy_o) |-> $past(reg_wr_i || rx_begin_i || rx_end_i
    || tx_begin_i || tx_end_i) || $past(ext_field_i) != $past(ext_field_i, 2)
    || $past(own_field_i) != $past(own_field_i, 2))
    else $error("A started without cause");
  a_busy_b_cause: assert property (
    $rose(timer_b_busy_o) |-> $past(reg_wr_i && reg_addr_i == 8'h40
    && reg_wdata_i[2])) else $error("B started without go");
endmodule

// File: sim/ret_top_test.sv
// ret_top_test: self-checking bench for the event timer set
// assumes ret_top and ret_checker are compiled before it
module ret_top_test
  import ret_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_i = 0;
  logic        rst_n_i = 0;
  logic [7:0]  reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0;
  logic        reg_wr_i = 0;
  logic        reg_rd_i = 0;
  logic        ext = 0;
  logic        own = 0;
  logic [8:0]  ev = 0;
  logic [31:0] rdata;
  logic [31:0] lf = 32'hf93e86bf;
  wire  [31:0] reg_rdata_o;
  wire         a_busy, b_busy, c_busy;
  int          error_cnt, comparisons, cyc, n, d;
  logic [7:0]  amap [8] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34,
                            8'h38, 8'h3c};
  int          sb [6] = '{20, 19, 18, 17, 16, 15};
  int          sc [6] = '{8, 2, 4, 5, 6, 7};

  // ---------------------------------------------------------------
  // design, clock, timeout
  // ---------------------------------------------------------------
  ret_top DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_begin_i(ev[0]), .rx_nibble_i(ev[8]), .rx_end_i(ev[1]),
    .tx_begin_i(ev[2]), .tx_end_i(ev[3]), .ext_field_i(ext),
    .own_field_i(own), .timer_a_busy_o(a_busy),
    .timer_b_busy_o(b_busy), .timer_c_busy_o(c_busy));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 0;
    #1 v = reg_rdata_o;
  endtask
  // codes 0..3 and 8 pulse an event, 4..7 move a field level
  task automatic trig(input int c);
    @(posedge ref_clk_i);
    case (c)
      4: ext <= 1;
      5: ext <= 0;
      6: own <= 1;
      7: own <= 0;
      default: ev[c] <= 1;
    endcase
    @(posedge ref_clk_i);
    ev <= 0;
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1;
    foreach (amap[i]) begin
      rd(amap[i], rdata);
      chk(rdata, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      lf = lfsr_next(lf);
      wr(amap[i], lf);
      rd(amap[i], rdata);
      chk(rdata, i < 3 ? 32'h0 : {12'h0, lf[19:0]});
    end
    $display("test registers done");
    wr(8'h2c, 32'h00fff);
    for (int k = 0; k < 8; k++) begin
      wr(8'h38, 32'h1 | (32'h1 << (14 - k)));
      chk(a_busy, 0);
      trig(k);
      chk(a_busy, 1);
      rd(8'h20, rdata);
      chk(rdata >= 32'h100ffe && rdata <= 32'h100fff, 1);
      wr(8'h38, 32'h0);
      chk(a_busy, 0);
    end
    $display("test start events done");
    for (int j = 0; j < 6; j++) begin
      wr(8'h38, 32'h41 | (32'h1 << sb[j]));
      chk(a_busy, 1);
      trig(sc[j]);
      chk(a_busy, 0);
      rd(8'h20, rdata);
      chk(rdata >= 32'hffe && rdata <= 32'hfff, 1);
    end
    $display("test stop events done");
    wr(8'h2c, 32'h3);
    for (int c = 0; c <= 8; c++) begin
      wr(8'h38, c == 8 ? 32'h41 : 32'h45 | (c << 3));
      d = c == 8 ? 1 : 1 << (c + 1);
      for (n = 0; a_busy === 1'b1 && n < 20000; n++) begin
        @(posedge ref_clk_i);
        #1;
      end
      chk(n >= 3 * d * 737 / 100 - 2 && n <= 4 * d * 737 / 100 + 10, 1);
      rd(8'h20, rdata);
      chk(rdata, 32'h0);
    end
    wr(8'h38, 32'h43);
    repeat (100) @(posedge ref_clk_i);
    #1 chk(a_busy, 1);
    wr(8'h38, 32'h0);
    $display("test tick rates done");
    wr(8'h30, 32'h3);
    wr(8'h34, 32'h5);
    wr(8'h40, 32'h0505);
    chk({b_busy, c_busy}, 2'b11);
    wr(8'h40, 32'h0909);
    chk({b_busy, c_busy}, 2'b00);
    rd(8'h24, rdata);
    chk(rdata >= 2 && rdata <= 3, 1);
    rd(8'h28, rdata);
    chk(rdata >= 4 && rdata <= 5, 1);
    wr(8'h40, 32'h0505);
    for (n = 0; (b_busy | c_busy) === 1'b1 && n < 200; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    rd(8'h28, rdata);
    chk(rdata, 32'h0);
    $display("test timers b c done");
    complete_run();
  end
endmodule

bind ret_top ret_checker u_chk (.*);
